// ===== hdl/phase_mux_pkg.sv
// Package with register map, field positions and carrier types for the phase pin mux.
`default_nettype none
package phase_mux_pkg;
  localparam int RegAddrWidth = 4;
  localparam int RegDataWidth = 16;
  // Register indices.
  localparam logic [3:0] SystemPinSelectAddr = 4'h0;
  localparam logic [3:0] PortCPullupAddr = 4'h1;
  localparam logic [3:0] PortCPeripheralAddr = 4'h2;
  localparam logic [3:0] PortCDirectionAddr = 4'h3;
  localparam logic [3:0] PortCDataAddr = 4'h4;
  localparam logic [3:0] TimerDirectionAddr = 4'h5;
  localparam logic [3:0] PinStatusAddr = 4'h6;
  // Field positions.
  localparam int PhaseAAltBit = 0;
  localparam int PhaseBAltBit = 1;
  localparam int PhaseABit = 0;
  localparam int PhaseBBit = 1;
  localparam int SerialMasterBit = 2;
  localparam int StatusFuncLsb = 4;
  // Reset values.
  localparam logic [15:0] PinSelectReset = 16'h0000;
  localparam logic [15:0] PullupReset = 16'h0003;
  localparam logic [15:0] PeripheralFullReset = 16'h0000;
  localparam logic [15:0] PeripheralReducedReset = 16'h0003;
  localparam logic [15:0] ZeroWord = 16'h0000;

  typedef enum logic [2:0] {
    FuncDecoder,
    FuncTimer,
    FuncSerial,
    FuncPort,
    FuncNone
  } pin_func_e;

  // One pin as seen from the pad.
  typedef struct packed {
    logic outVal;
    logic outEn;
    logic pullEn;
  } pad_drive_s;

  // Peripheral-side signals for one pin.
  typedef struct packed {
    logic outVal;
    logic outEn;
  } periph_out_s;
endpackage
`default_nettype wire

// ===== hdl/decoder_one_phase_pin_mux.sv
// Pin mux for the two phase pins of the second quadrature decoder.
`default_nettype none
//
// Contract
// - Phase-A alternate-select bit routes first pin to serial clock.
// - Phase-B alternate-select bit routes second pin to serial data out.
// - Full variant: first pin resets to decoder phase-A input.
// - Full variant: second pin resets to decoder phase-B input.
// - Clearing pull-up bit 0 disables first pin pull-up.
// - Clearing pull-up bit 1 disables second pin pull-up.
// - Serial clock pin drives in master mode, is input in slave mode.
// - Master presents data half a clock before slave sampling edge.
// - Port role: each pin individually input or output.
// - Pins also serve as timer channels 0 and 1, in or out.
module decoder_one_phase_pin_mux
  import phase_mux_pkg::*;
#(
  parameter bit FullVariant = 1'b1
)
(
  // Clock, reset, enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  // Register port.
  input wire logic [RegAddrWidth-1:0] regAddr,
  input wire logic [RegDataWidth-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [RegDataWidth-1:0] regRdData,
  // Pads: input, output, output enable, pull-up enable.
  input wire logic [1:0] padIn,
  output logic [1:0] padOut,
  output logic [1:0] padOutEn,
  output logic [1:0] padPullEn,
  // Decoder phase inputs.
  output logic decoder_one_phase_a_input,
  output logic decoder_one_phase_b_input,
  // Timer channels 0 and 1.
  input wire logic timer_two_channel_zero_out,
  input wire logic timer_two_channel_one_out,
  output logic timer_two_channel_zero_in,
  output logic timer_two_channel_one_in,
  // Serial interface clock and master-out data.
  input wire logic serial_if_one_clock_out,
  input wire logic serial_if_one_master_out_data_out,
  output logic serial_if_one_clock_in,
  output logic serial_if_one_master_out_data_in,
  // Port C lines 0 and 1 as read by the port.
  output logic port_c_line_zero,
  output logic port_c_line_one
);

  ////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [RegDataWidth-1:0] pinSelect_q, pinSelect_d;
  logic [RegDataWidth-1:0] pullup_q, pullup_d;
  logic [RegDataWidth-1:0] periph_q, periph_d;
  logic [RegDataWidth-1:0] portDir_q, portDir_d;
  logic [RegDataWidth-1:0] portData_q, portData_d;
  logic [RegDataWidth-1:0] timerDir_q, timerDir_d;
  logic [RegDataWidth-1:0] rdData_q, rdData_d;
  logic [1:0] padSync1_q, padSync2_q;
  pin_func_e func [2];
  pad_drive_s drive [2];
  logic [1:0] periphOut, periphOutEn;
  logic [RegDataWidth-1:0] statusWord;

  always_comb
  begin
    pinSelect_d = pinSelect_q;
    pullup_d = pullup_q;
    periph_d = periph_q;
    portDir_d = portDir_q;
    portData_d = portData_q;
    timerDir_d = timerDir_q;
    rdData_d = rdData_q;
    if (regWr)
    begin
      case (regAddr)
        SystemPinSelectAddr: pinSelect_d = regWrData;
        PortCPullupAddr: pullup_d = regWrData;
        PortCPeripheralAddr: periph_d = regWrData;
        PortCDirectionAddr: portDir_d = regWrData;
        PortCDataAddr: portData_d = regWrData;
        TimerDirectionAddr: timerDir_d = regWrData;
        default: ;
      endcase
    end
    if (regRd)
    begin
      case (regAddr)
        SystemPinSelectAddr: rdData_d = pinSelect_q;
        PortCPullupAddr: rdData_d = pullup_q;
        PortCPeripheralAddr: rdData_d = periph_q;
        PortCDirectionAddr: rdData_d = portDir_q;
        PortCDataAddr: rdData_d = portData_q;
        TimerDirectionAddr: rdData_d = timerDir_q;
        PinStatusAddr: rdData_d = statusWord;
        default: rdData_d = ZeroWord;
      endcase
    end
    else
    begin
      rdData_d = ZeroWord;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pinSelect_q <= PinSelectReset;
      pullup_q <= PullupReset;
      periph_q <= FullVariant ? PeripheralFullReset : PeripheralReducedReset;
      portDir_q <= ZeroWord;
      portData_q <= ZeroWord;
      timerDir_q <= ZeroWord;
      rdData_q <= ZeroWord;
    end
    else if (clkEn)
    begin
      pinSelect_q <= pinSelect_d;
      pullup_q <= pullup_d;
      periph_q <= periph_d;
      portDir_q <= portDir_d;
      portData_q <= portData_d;
      timerDir_q <= timerDir_d;
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

  ////////////////////////////////////////////////////////////////////////
  // Pad input synchroniser.

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      padSync1_q <= 2'h0;
      padSync2_q <= 2'h0;
    end
    else if (clkEn)
    begin
      padSync1_q <= padIn;
      padSync2_q <= padSync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Function selection per pin.

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (pinSelect_q[i])
        func[i] = FuncSerial;
      else if (portDir_q[i] && !periph_q[i])
        func[i] = FuncPort;
      else if (timerDir_q[i])
        func[i] = FuncTimer;
      else if (periph_q[i])
        func[i] = FuncNone;
      else
        func[i] = FuncDecoder;
    end
  end

  // Peripheral drive per pin; serial clock drives only in master mode.
  always_comb
  begin
    periphOut[PhaseABit] = serial_if_one_clock_out;
    periphOut[PhaseBBit] = serial_if_one_master_out_data_out;
    periphOutEn[PhaseABit] = timerDir_q[SerialMasterBit];
    periphOutEn[PhaseBBit] = timerDir_q[SerialMasterBit];
  end

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      drive[i].outVal = 1'b0;
      drive[i].outEn = 1'b0;
      drive[i].pullEn = pullup_q[i];
      case (func[i])
        FuncSerial:
        begin
          drive[i].outVal = periphOut[i];
          drive[i].outEn = periphOutEn[i];
        end
        FuncPort:
        begin
          drive[i].outVal = portData_q[i];
          drive[i].outEn = 1'b1;
        end
        FuncTimer:
        begin
          drive[i].outVal = (i == 0) ? timer_two_channel_zero_out : timer_two_channel_one_out;
          drive[i].outEn = 1'b1;
        end
        default: ;
      endcase
      padOut[i] = drive[i].outVal;
      padOutEn[i] = drive[i].outEn;
      padPullEn[i] = drive[i].pullEn;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Inputs to the peripherals.

  always_comb
  begin
    decoder_one_phase_a_input = (func[PhaseABit] == FuncDecoder) & padSync2_q[PhaseABit];
    decoder_one_phase_b_input = (func[PhaseBBit] == FuncDecoder) & padSync2_q[PhaseBBit];
    timer_two_channel_zero_in = padSync2_q[PhaseABit];
    timer_two_channel_one_in = padSync2_q[PhaseBBit];
    serial_if_one_clock_in = (func[PhaseABit] == FuncSerial) & padSync2_q[PhaseABit];
    serial_if_one_master_out_data_in = (func[PhaseBBit] == FuncSerial) & padSync2_q[PhaseBBit];
    port_c_line_zero = padSync2_q[PhaseABit];
    port_c_line_one = padSync2_q[PhaseBBit];
    statusWord = ZeroWord;
    statusWord[PhaseBBit:PhaseABit] = padSync2_q;
    statusWord[StatusFuncLsb +: 3] = func[PhaseABit];
    statusWord[StatusFuncLsb + 3 +: 3] = func[PhaseBBit];
  end

endmodule
`default_nettype wire

// ===== dv/decoder_one_phase_pin_mux_properties.sv
// Port checker for the phase pin mux.
`default_nettype none
module phase_mux_checker
  import phase_mux_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic [RegAddrWidth-1:0] regAddr,
  input wire logic [RegDataWidth-1:0] regWrData,
  input wire logic regWr,
  input wire logic [1:0] padIn,
  input wire logic [1:0] padOut,
  input wire logic [1:0] padOutEn,
  input wire logic [1:0] padPullEn,
  input wire logic decoder_one_phase_a_input,
  input wire logic serial_if_one_clock_out,
  input wire logic serial_if_one_master_out_data_out,
  input wire logic serial_if_one_clock_in,
  input wire logic port_c_line_zero
);
  // Shadow of both alternate selects (bits 1:0) and the serial master bit (bit 2).
  logic [2:0] sel_q;
  always_ff @(posedge clk)
    if (srst)
      sel_q <= 3'h0;
    else if (clkEn && regWr && regAddr == SystemPinSelectAddr)
      sel_q[1:0] <= regWrData[1:0];
    else if (clkEn && regWr && regAddr == TimerDirectionAddr)
      sel_q[2] <= regWrData[SerialMasterBit];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  padSync_a: assert property (clkEn && $past(clkEn) && $past(clkEn, 2) && !$past(srst) && !$past(srst, 2)
    |-> port_c_line_zero == $past(padIn[0], 2)) else $error("pad sync lag wrong");
  resetPads_a: assert property ($past(srst) |-> padPullEn == 2'b11 && padOutEn == 2'b00)
    else $error("pads not at reset state");
  pullFollow_a: assert property (regWr && clkEn && regAddr == PortCPullupAddr
    |=> padPullEn == $past(regWrData[1:0])) else $error("pull-up not as written");
  masterClock_a: assert property (sel_q[0] && sel_q[2]
    |-> padOutEn[0] && padOut[0] == serial_if_one_clock_out) else $error("serial clock not driven");
  slaveClock_a: assert property (sel_q[0] && !sel_q[2] |-> !padOutEn[0])
    else $error("slave clock pin driven");
  masterData_a: assert property (sel_q[1] && sel_q[2]
    |-> padOutEn[1] && padOut[1] == serial_if_one_master_out_data_out) else $error("serial data not driven");
  clockRoute_a: assert property (serial_if_one_clock_in == (sel_q[0] && port_c_line_zero))
    else $error("serial clock input wrong");
  decoderOff_a: assert property (sel_q[0] |-> !decoder_one_phase_a_input)
    else $error("decoder sees claimed pin");
  cover property (sel_q == 3'h7);
  cover property ($fell(padPullEn[1]));
  cover property (serial_if_one_clock_in);
endmodule
bind decoder_one_phase_pin_mux phase_mux_checker chk (.*);
`default_nettype wire

// ===== dv/pad_partner.sv
// Far side of the two pads: an external driver, pull-ups and floating lines.
`default_nettype none
module pad_partner (
  input wire logic clk,
  input wire logic [1:0] padOut,
  input wire logic [1:0] padOutEn,
  input wire logic [1:0] padPullEn,
  input wire logic [1:0] extVal,
  input wire logic [1:0] extEn,
  output logic [1:0] padIn
);
  logic [1:0] last_q = 2'b00;
  always_ff @(posedge clk)
    last_q <= padIn;
  // A line nobody drives and nothing pulls up drifts away from its last level.
  always_comb
    for (int i = 0; i < 2; i++)
      padIn[i] = padOutEn[i] ? padOut[i] : extEn[i] ? extVal[i] : padPullEn[i] ? 1'b1 : ~last_q[i];
endmodule
`default_nettype wire

// ===== dv/decoder_one_phase_pin_mux_bench.sv
// Self-checking bench for the phase pin mux.
`default_nettype none
module decoder_one_phase_pin_mux_bench import phase_mux_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] data;
    logic [5:0] pins;
  } row_s;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic clkEn = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic [15:0] regRdData;
  logic [1:0] padIn, padOut, padOutEn, padPullEn;
  logic [1:0] extVal = 2'b00;
  logic [1:0] extEn = 2'b00;
  logic decoder_one_phase_a_input, decoder_one_phase_b_input, timer_two_channel_zero_in, timer_two_channel_one_in;
  logic serial_if_one_clock_in, serial_if_one_master_out_data_in, port_c_line_zero, port_c_line_one;
  logic [1:0] redDec;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Each row: register write, then output enables, driven levels and pull-ups.
  row_s rows [10] = '{'{4'h1, 16'h0002, 6'b000010}, '{4'h1, 16'h0001, 6'b000001}, '{4'h4, 16'h0003, 6'b000001},
    '{4'h3, 16'h0001, 6'b010101}, '{4'h3, 16'h0002, 6'b101001}, '{4'h3, 16'h0000, 6'b000001},
    '{4'h5, 16'h0003, 6'b111001}, '{4'h5, 16'h0004, 6'b000001}, '{4'h0, 16'h0003, 6'b110101},
    '{4'h5, 16'h0000, 6'b000001}};
  always #20 clk = ~clk;
  decoder_one_phase_pin_mux DUT (.timer_two_channel_zero_out(1'b0), .timer_two_channel_one_out(1'b1),
    .serial_if_one_clock_out(1'b1), .serial_if_one_master_out_data_out(1'b0), .*);
  pad_partner far (.*);
  // Reduced variant with both pads held high; its decoder inputs stay dead until software reconfigures the pins.
  decoder_one_phase_pin_mux #(.FullVariant(1'b0)) DUT2 (.clk(clk), .srst(srst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(), .padIn(2'b11), .padOut(), .padOutEn(),
    .padPullEn(), .decoder_one_phase_a_input(redDec[0]), .decoder_one_phase_b_input(redDec[1]),
    .timer_two_channel_zero_out(1'b0), .timer_two_channel_one_out(1'b0), .timer_two_channel_zero_in(),
    .timer_two_channel_one_in(), .serial_if_one_clock_out(1'b0), .serial_if_one_master_out_data_out(1'b0),
    .serial_if_one_clock_in(), .serial_if_one_master_out_data_in(), .port_c_line_zero(), .port_c_line_one());
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk("read", regRdData, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #100us;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    #1 chk("pull", 16'(padPullEn), 16'h0003);
    chk("oe", 16'(padOutEn), 16'h0000);
    rdc(4'h1, PullupReset);
    rdc(4'h2, PeripheralFullReset);
    rdc(4'hF, ZeroWord);
    chk("red", 16'(redDec), 16'h0000);
    wr(4'h2, ZeroWord);
    settle();
    chk("red", 16'(redDec), 16'h0003);
    extEn <= 2'b11;
    extVal <= 2'b10;
    settle();
    chk("dec", 16'({decoder_one_phase_b_input, decoder_one_phase_a_input}), 16'h0002);
    chk("tmr", 16'({timer_two_channel_one_in, timer_two_channel_zero_in}), 16'h0002);
    extEn <= 2'b00;
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].data);
      chk("pins", 16'({padOutEn, padOut & padOutEn, padPullEn}), 16'(rows[i].pins));
    end
    extEn <= 2'b11;
    extVal <= 2'b01;
    settle();
    chk("ser", 16'({serial_if_one_master_out_data_in, serial_if_one_clock_in}), 16'h0001);
    chk("dec", 16'({decoder_one_phase_b_input, decoder_one_phase_a_input}), 16'h0000);
    extEn <= 2'b00;
    wr(4'hF, 16'hFFFF);
    rdc(4'h0, 16'h0003);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1 chk("oe", 16'(padOutEn), 16'h0000);
    rdc(4'h0, PinSelectReset);
    @(posedge clk);
    clkEn <= 1'b0;
    wr(4'h1, ZeroWord);
    chk("frozen", 16'(padPullEn), 16'h0003);
    @(posedge clk);
    clkEn <= 1'b1;
    report_and_stop();
  end
endmodule
`default_nettype wire
